//--- hw/sagc_config.v
// spectral adc agc, auto-zero and fifo threshold configuration logic
//
// What this block does
// - with spectral agc on, lower gain once data exceeds high threshold 50..87.5%
// - full scale is (step count + 1) times (step size + 1)
// - with spectral agc on, raise gain when data below low threshold 12.5..50%
// - flicker status changes after persistence count of differing results
// - flicker interrupt raised only once persistence condition met
// - auto-zero interval: 0 never, n every n cycles, 255 first only
// - auto-zero takes about 15 ms; measurement waits for it
// - with flicker detect on, auto-zero also hits fifth adc, restarting flicker
// - flicker agc gain never above flicker ceiling code, reset 9
// - spectral agc gain never above spectral ceiling code, reset 9
// - fifo interrupt when fill level reaches 1, 4, 8 or 16
// - flicker agc enable, reset one, steers flicker gain automatically
// - spectral agc enable, reset zero, steers spectral gain automatically
`timescale 1ns/1ps
`include "sagc_consts.vh"
module sagc_config #(
  parameter AZ_CYCLES = `SAGC_AZ_CYCLES
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // register port
  input  wire        regWr,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata,
  // measurement engine
  input  wire [7:0]  integrationStepCount,
  input  wire [15:0] integrationStepSize,
  input  wire        cycleStart,
  input  wire        dataValid,
  input  wire [15:0] channelData,
  input  wire        flickerResultValid,
  input  wire        flickerResult,
  input  wire        flickerDetectEn,
  input  wire [4:0]  fifoFillLevel,
  // outputs
  output reg  [3:0]  spectralGain,
  output reg  [3:0]  flickerGain,
  output reg         autozeroBusy,
  output reg         autozeroAdc5,
  output reg         flickerRestart,
  output reg         flickerStatus,
  output reg         syncInterruptPin,
  output reg         fifoInterrupt
);

  ////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] fifoAgc_q, hystPers_q, gainCeil_q, azInt_q;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fifoAgc_q  <= `SAGC_RST_FIFO_AGC;
      hystPers_q <= `SAGC_RST_HYST_PERS;
      gainCeil_q <= `SAGC_RST_GAIN_CEIL;
      azInt_q    <= `SAGC_RST_AZ_INT;
    end else if (regWr) begin
      case (regAddr)
        `SAGC_ADDR_FIFO_AGC:  fifoAgc_q  <= regWdata & `SAGC_MASK_FIFO_AGC;
        `SAGC_ADDR_HYST_PERS: hystPers_q <= regWdata & `SAGC_MASK_HYST_PERS;
        `SAGC_ADDR_GAIN_CEIL: gainCeil_q <= regWdata & `SAGC_MASK_GAIN_CEIL;
        `SAGC_ADDR_AZ_INT:    azInt_q    <= regWdata;
        default: begin
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else begin
      case (regAddr)
        `SAGC_ADDR_FIFO_AGC:  regRdata <= fifoAgc_q;
        `SAGC_ADDR_HYST_PERS: regRdata <= hystPers_q;
        `SAGC_ADDR_GAIN_CEIL: regRdata <= gainCeil_q;
        `SAGC_ADDR_AZ_INT:    regRdata <= azInt_q;
        default:              regRdata <= 8'h00;
      endcase
    end
  end

  wire       spectralAutoEn = fifoAgc_q[`SAGC_SPECTRAL_AUTO];
  wire       flickerAutoEn  = fifoAgc_q[`SAGC_FLICKER_AUTO];
  wire [1:0] fifoLevelSel   = fifoAgc_q[`SAGC_FIFO_LEVEL_HI:`SAGC_FIFO_LEVEL_LO];
  wire [1:0] hiSel          = hystPers_q[`SAGC_HIGH_HYST_HI:`SAGC_HIGH_HYST_LO];
  wire [1:0] loSel          = hystPers_q[`SAGC_LOW_HYST_HI:`SAGC_LOW_HYST_LO];
  wire [2:0] pers     = hystPers_q[`SAGC_PERS_HI:`SAGC_PERS_LO];
  wire [3:0] fdCeil   = gainCeil_q[`SAGC_FDMAX_HI:`SAGC_FDMAX_LO];
  wire [3:0] spCeil   = gainCeil_q[`SAGC_SPMAX_HI:`SAGC_SPMAX_LO];

  ////////////////////////////////////////////////////////////////////
  // spectral agc thresholds
  // full scale in eighths; 25 bits keeps the product exact
  wire [24:0] fullScale = {16'h0000, integrationStepCount} + 25'h0000001;
  wire [24:0] stepPlus  = {9'h000, integrationStepSize} + 25'h0000001;
  wire [49:0] fsProd    = fullScale * stepPlus;
  wire [27:0] fsEighth  = fsProd[30:3];
  wire [27:0] hiThresh  = fsEighth * {25'h0, 3'h4 + {1'b0, hiSel}};
  wire [27:0] loThresh  = fsEighth * {25'h0, 3'h1 + {1'b0, loSel}};
  wire [27:0] dataWide  = {12'h000, channelData};

  // ceiling codes above the top gain act as the top gain
  function [3:0] gainTop;
    input [3:0] ceilCode;
    begin
      gainTop = (ceilCode > `SAGC_GAIN_TOP) ? `SAGC_GAIN_TOP : ceilCode;
    end
  endfunction

  function [3:0] clampGain;
    input [3:0] gain;
    input [3:0] ceilCode;
    begin
      clampGain = (gain > gainTop(ceilCode)) ? gainTop(ceilCode) : gain;
    end
  endfunction

  // every step is clamped so a freshly lowered ceiling is never overshot
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spectralGain <= `SAGC_RST_GAIN;
    end else if (spectralAutoEn && dataValid) begin
      if (dataWide > hiThresh && spectralGain != `SAGC_GAIN_MIN)
        spectralGain <= clampGain(spectralGain - 4'h1, spCeil);
      else if (dataWide < loThresh && spectralGain < gainTop(spCeil))
        spectralGain <= spectralGain + 4'h1;
      else
        spectralGain <= clampGain(spectralGain, spCeil);
    end else begin
      spectralGain <= clampGain(spectralGain, spCeil);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flicker agc: saturating result lowers gain, data below low threshold raises it toward ceiling
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flickerGain <= `SAGC_RST_GAIN;
    end else if (flickerAutoEn && dataValid) begin
      if (channelData == `SAGC_FD_SAT && flickerGain != `SAGC_GAIN_MIN)
        flickerGain <= clampGain(flickerGain - 4'h1, fdCeil);
      else if (dataWide < loThresh && flickerGain < gainTop(fdCeil))
        flickerGain <= flickerGain + 4'h1;
      else
        flickerGain <= clampGain(flickerGain, fdCeil);
    end else begin
      flickerGain <= clampGain(flickerGain, fdCeil);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flicker persistence: needs 2^(pers-1) differing results, pers 0 means 1
  wire [7:0] persNeed = (pers == 3'h0) ? 8'h01 : (8'h01 << (pers - 3'h1));
  reg  [7:0] persCnt_q;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      persCnt_q        <= 8'h00;
      flickerStatus    <= 1'b0;
      syncInterruptPin <= 1'b0;
    end else begin
      syncInterruptPin <= 1'b0;
      if (flickerResultValid) begin
        if (flickerResult == flickerStatus) begin
          persCnt_q <= 8'h00;
        end else if (persCnt_q + 8'h01 >= persNeed) begin
          persCnt_q        <= 8'h00;
          flickerStatus    <= flickerResult;
          syncInterruptPin <= 1'b1;
        end else begin
          persCnt_q <= persCnt_q + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // auto-zero scheduler
  reg [7:0]  azCnt_q;
  reg        azFirstDone_q;
  reg [31:0] azTimer_q;
  wire       azDue = (azInt_q == `SAGC_AZ_FIRST_ONLY) ? !azFirstDone_q :
                     (azInt_q != `SAGC_AZ_NEVER) && (azCnt_q + 8'h01 >= azInt_q);

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      azCnt_q        <= 8'h00;
      azFirstDone_q  <= 1'b0;
      azTimer_q      <= 32'h0;
      autozeroBusy   <= 1'b0;
      autozeroAdc5   <= 1'b0;
      flickerRestart <= 1'b0;
    end else begin
      flickerRestart <= 1'b0;
      if (autozeroBusy) begin
        // engine must hold off the next cycle until this clears
        if (azTimer_q == 32'h1) begin
          autozeroBusy <= 1'b0;
          autozeroAdc5 <= 1'b0;
          flickerRestart <= autozeroAdc5;
        end
        azTimer_q <= azTimer_q - 32'h1;
      end else if (cycleStart) begin
        if (azDue) begin
          azCnt_q       <= 8'h00;
          azFirstDone_q <= 1'b1;
          autozeroBusy  <= 1'b1;
          autozeroAdc5  <= flickerDetectEn;
          azTimer_q     <= AZ_CYCLES;
        end else begin
          azCnt_q <= azCnt_q + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fifo threshold
  function [4:0] fifoLevelOf;
    input [1:0] code;
    begin
      case (code)
        2'h0:    fifoLevelOf = 5'h01;
        2'h1:    fifoLevelOf = 5'h04;
        2'h2:    fifoLevelOf = 5'h08;
        default: fifoLevelOf = 5'h10;
      endcase
    end
  endfunction

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      fifoInterrupt <= 1'b0;
    else
      fifoInterrupt <= (fifoFillLevel >= fifoLevelOf(fifoLevelSel));
  end

endmodule

//--- hw/sagc_consts.vh
// constants for the spectral adc agc / auto-zero configuration block
`ifndef SAGC_CONSTS_VH
`define SAGC_CONSTS_VH
// register addresses
`define SAGC_ADDR_FIFO_AGC   8'hb1
`define SAGC_ADDR_HYST_PERS  8'hb3
`define SAGC_ADDR_GAIN_CEIL  8'hcf
`define SAGC_ADDR_AZ_INT     8'hd6
// reset values
`define SAGC_RST_FIFO_AGC    8'h88
`define SAGC_RST_HYST_PERS   8'hf2
`define SAGC_RST_GAIN_CEIL   8'h99
`define SAGC_RST_AZ_INT      8'hff
// writable bit masks (reserved bits zero)
`define SAGC_MASK_FIFO_AGC   8'hcc
`define SAGC_MASK_HYST_PERS  8'hf7
`define SAGC_MASK_GAIN_CEIL  8'hff
`define SAGC_MASK_AZ_INT     8'hff
// fields
`define SAGC_FIFO_LEVEL_HI   7
`define SAGC_FIFO_LEVEL_LO   6
`define SAGC_FLICKER_AUTO    3
`define SAGC_SPECTRAL_AUTO   2
`define SAGC_HIGH_HYST_HI    7
`define SAGC_HIGH_HYST_LO    6
`define SAGC_LOW_HYST_HI     5
`define SAGC_LOW_HYST_LO     4
`define SAGC_PERS_HI         2
`define SAGC_PERS_LO         0
`define SAGC_FDMAX_HI        7
`define SAGC_FDMAX_LO        4
`define SAGC_SPMAX_HI        3
`define SAGC_SPMAX_LO        0
// auto-zero codes
`define SAGC_AZ_NEVER        8'h00
`define SAGC_AZ_FIRST_ONLY   8'hff
// gain limits
`define SAGC_GAIN_MIN        4'h0
`define SAGC_GAIN_TOP        4'ha
`define SAGC_RST_GAIN        4'h9
// flicker data code taken as saturated
`define SAGC_FD_SAT          16'hffff
// auto-zero duration in microseconds and clock
`define SAGC_AZ_TIME_US      15000
`define SAGC_CLK_MHZ         100
`define SAGC_AZ_CYCLES       (`SAGC_AZ_TIME_US * `SAGC_CLK_MHZ)
`endif

//--- testbench/sagc_config_chk.sv
// assertion checker for the agc / auto-zero configuration block
`timescale 1ns/1ps
module sagc_config_chk #(parameter AZ_CYCLES = 10) (
  // clock, reset, register writes
  input wire       sys_clk, nrst, regWr,
  input wire [7:0] regAddr, regWdata,
  // engine side and outputs
  input wire       cycleStart, dataValid, flickerResultValid, flickerResult, flickerDetectEn,
  input wire [4:0] fifoFillLevel,
  input wire [3:0] spectralGain, flickerGain,
  input wire       autozeroBusy, autozeroAdc5, flickerStatus, syncInterruptPin, fifoInterrupt
);
  reg [1:0]  thrQ;
  reg [7:0]  ceilQ;
  reg [31:0] azCntQ;
  // threshold and ceilings mirrored from writes, the registers are not ports
  wire [4:0] lvl   = thrQ == 2'h0 ? 5'h01 : 5'h02 << thrQ;
  wire [3:0] spTop = ceilQ[3:0] > 4'ha ? 4'ha : ceilQ[3:0];
  wire [3:0] fdTop = ceilQ[7:4] > 4'ha ? 4'ha : ceilQ[7:4];
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      thrQ <= 2'h2;
      ceilQ <= 8'h99;
      azCntQ <= 32'h0;
    end else begin
      if (regWr && regAddr == 8'hb1) thrQ <= regWdata[7:6];
      if (regWr && regAddr == 8'hcf) ceilQ <= regWdata;
      azCntQ <= autozeroBusy ? azCntQ + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_FIFO_LEVEL: assert property (fifoInterrupt == ($past(fifoFillLevel) >= $past(lvl)))
    else $error("fifo flag wrong");
  AST_GAIN_CEIL: assert property (spectralGain <= 4'ha && flickerGain <= 4'ha)
    else $error("gain above top");
  // one cycle of grace after a ceiling write while the clamp lands
  AST_SP_CEIL: assert property (!$past(regWr) |-> spectralGain <= spTop)
    else $error("spectral gain above ceiling");
  AST_FD_CEIL: assert property (!$past(regWr) |-> flickerGain <= fdTop)
    else $error("flicker gain above ceiling");
  AST_SPG_CAUSE: assert property ($changed(spectralGain) |->
    $past(dataValid) || $past(dataValid, 2) || $past(regWr) || $past(regWr, 2))
    else $error("gain moved unprompted");
  AST_FDG_STEP: assert property ($changed(flickerGain) && !$past(regWr) && !$past(regWr, 2) |->
    flickerGain == $past(flickerGain) + 4'h1 || flickerGain == $past(flickerGain) - 4'h1)
    else $error("flicker gain jumped");
  AST_AZ_START: assert property ($rose(autozeroBusy) |->
    $past(cycleStart) && autozeroAdc5 == $past(flickerDetectEn)) else $error("auto-zero start");
  AST_AZ_LEN: assert property ($fell(autozeroBusy) |-> azCntQ == AZ_CYCLES)
    else $error("auto-zero length");
  AST_STATUS: assert property ($changed(flickerStatus) |->
    $past(flickerResultValid) && $past(flickerResult) == flickerStatus) else $error("status flip");
  AST_SYNC_INT: assert property (syncInterruptPin |-> $changed(flickerStatus))
    else $error("stray interrupt");
  cover property ($rose(autozeroBusy));
  cover property (syncInterruptPin);
  cover property (fifoInterrupt);
endmodule
bind sagc_config sagc_config_chk #(.AZ_CYCLES(AZ_CYCLES)) u_chk (.*);

//--- testbench/sagc_config_test.sv
// self-checking bench for the agc / auto-zero configuration block
`timescale 1ns/1ps
module sagc_config_test;
  reg        sys_clk = 1'h0, nrst = 1'h0, regWr = 1'h0, cycleStart = 1'h0, dataValid = 1'h0;
  reg        flickerResultValid = 1'h0, flickerResult = 1'h0, flickerDetectEn = 1'h1;
  reg [7:0]  regAddr = 8'h0, regWdata = 8'h0, integrationStepCount = 8'h0f;
  reg [15:0] integrationStepSize = 16'hf, channelData = 16'h0;
  reg [4:0]  fifoFillLevel = 5'h0;
  wire [7:0] regRdata;
  wire [3:0] spectralGain, flickerGain;
  wire       autozeroBusy, autozeroAdc5, flickerRestart, flickerStatus, syncInterruptPin;
  wire       fifoInterrupt;
  reg [7:0]  mir [0:255];
  integer    fail_count = 0, check_count = 0, seed = 32'h78e03e6d;
  integer    i, j, n, st = 0, sg = 9, fg = 9, nInt = 0, nAz = 0, nRs = 0, f8, hi, lo;
  sagc_config #(.AZ_CYCLES(10)) u_dut (.*);
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    nInt <= nInt + syncInterruptPin;
    nRs <= nRs + flickerRestart;
    if ($rose(autozeroBusy)) nAz <= nAz + 1;
  end
  task chk(input string nm, input [15:0] seen, exp); begin
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  end endtask
  task wr(input [7:0] a, d); begin
    @(posedge sys_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'h0;
    mir[a] = d & (a == 8'hb1 ? 8'hcc : a == 8'hb3 ? 8'hf7 : a == 8'hcf || a == 8'hd6 ? 8'hff : 8'h0);
  end endtask
  task rd(input [7:0] a); begin
    @(posedge sys_clk);
    regAddr <= a;
    repeat (2) @(posedge sys_clk);
    #1 chk("regRdata", regRdata, mir[a]);
  end endtask
  task dv(input [15:0] d); begin
    @(posedge sys_clk);
    dataValid <= 1'h1;
    channelData <= d;
    @(posedge sys_clk);
    dataValid <= 1'h0;
    if (mir[8'hb1][2] && d > hi && sg > 0) sg = sg - 1;
    else if (mir[8'hb1][2] && d < lo && sg < mir[8'hcf][3:0]) sg = sg + 1;
    if (mir[8'hb1][3] && d == 16'hffff && fg > 0) fg = fg - 1;
    else if (mir[8'hb1][3] && d < lo && fg < mir[8'hcf][7:4]) fg = fg + 1;
    repeat (2) @(posedge sys_clk);
    #1 chk("gains", {spectralGain, flickerGain}, {sg[3:0], fg[3:0]});
  end endtask
  task fr(input r); begin
    @(posedge sys_clk);
    flickerResultValid <= 1'h1;
    flickerResult <= r;
    @(posedge sys_clk);
    flickerResultValid <= 1'h0;
    repeat (2) @(posedge sys_clk);
  end endtask
  // cycle starts spaced past the busy time so none are ignored
  task az(input integer k, e); integer a0, r0; begin
    a0 = nAz;
    r0 = nRs;
    repeat (k) begin
      @(posedge sys_clk);
      cycleStart <= 1'h1;
      @(posedge sys_clk);
      cycleStart <= 1'h0;
      repeat (15) @(posedge sys_clk);
    end
    chk("autozero runs", nAz - a0, e);
    chk("restarts", nRs - r0, flickerDetectEn ? e : 0);
  end endtask
  task print_verdict; begin
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end endtask
  initial begin
    for (i = 0; i < 256; i = i + 1) mir[i] = 8'h0;
    mir[8'hb1] = 8'h88;
    mir[8'hb3] = 8'hf2;
    mir[8'hcf] = 8'h99;
    mir[8'hd6] = 8'hff;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'h1;
    for (i = 0; i < 256; i = i + 1) rd(i);
    az(4, 1);
    @(posedge sys_clk) flickerDetectEn <= 1'h0;
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'hd6, i == 0 ? 8'h1 : i == 1 ? 8'h3 : 8'h0);
      az(i == 0 ? 3 : i == 1 ? 9 : 4, i < 2 ? 3 : 0);
    end
    wr(8'hcf, 8'h9a);
    wr(8'hb1, 8'h8c);
    f8 = (integrationStepCount + 1) * (integrationStepSize + 1) / 8;
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'hb3, {i[1:0], i[1:0], 4'h2});
      hi = f8 * (4 + i);
      lo = f8 * (1 + i);
      dv(hi + 1);
      dv(hi);
      dv(lo - 1);
      dv(lo);
      dv(lo - 1);
    end
    dv(16'hffff);
    dv(16'h0);
    wr(8'hb1, 8'h80);
    dv(16'hffff);
    // lowered ceilings pull both gains down even with the loops off
    wr(8'hcf, 8'h35);
    sg = 5;
    fg = 3;
    dv(16'h0);
    for (i = 0; i < 5; i = i + 1) begin
      wr(8'hb3, 8'hf0 | i);
      n = i == 0 ? 1 : 1 << (i - 1);
      for (j = 1; j < n; j = j + 1) fr(!st);
      fr(st);
      for (j = 1; j < n; j = j + 1) fr(!st);
      chk("flickerStatus", flickerStatus, st);
      fr(!st);
      st = !st;
      chk("flickerStatus", flickerStatus, st);
      chk("interrupts", nInt, i + 1);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'hb1, {i[1:0], 6'h0c});
      n = i == 0 ? 1 : 2 << i;
      for (j = n - 1; j <= n; j = j + 1) begin
        @(posedge sys_clk) fifoFillLevel <= j;
        repeat (3) @(posedge sys_clk);
        #1 chk("fifoInterrupt", fifoInterrupt, j == n);
      end
    end
    for (i = 0; i < 12; i = i + 1) begin
      n = $random(seed);
      j = 32'hb1b3cfd6 >> {n[9:8], 3'h0};
      wr(j[7:0], n[7:0]);
      rd(j[7:0]);
    end
    print_verdict;
  end
endmodule
